// ### design/mbs_defs.svh
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH
// Function codes served by the interpreter.
`define MBS_FC_RD_BITS 8'h02
`define MBS_FC_RD_WORDS 8'h03
`define MBS_FC_WR_BIT 8'h05
`define MBS_FC_WR_WORD 8'h06
`define MBS_FC_WR_BITS 8'h0F
`define MBS_FC_WR_WORDS 8'h10
// Exception marking and exception codes.
`define MBS_EXC_FLAG 8'h80
`define MBS_EXC_FUNC 8'h01
`define MBS_EXC_ADDR 8'h02
`define MBS_EXC_VALUE 8'h03
// Address windows of the bit and word areas.
`define MBS_IBIT_LO 16'h6000
`define MBS_IBIT_HI 16'h63FF
`define MBS_QBIT_LO 16'hA000
`define MBS_QBIT_HI 16'hA3FF
`define MBS_IWORD_LO 16'h8000
`define MBS_IWORD_HI 16'h803F
`define MBS_QWORD_LO 16'hA000
`define MBS_QWORD_HI 16'hA03F
`define MBS_MWORD_HI 16'h7FFF
// Single bit write values.
`define MBS_BIT_OFF 16'h0000
`define MBS_BIT_ON 16'hFF00
// Largest quantities accepted per request.
`define MBS_MAX_RD_BITS 16'h07D0
`define MBS_MAX_WR_BITS 16'h07B0
`define MBS_MAX_RD_WORDS 16'h007D
`define MBS_MAX_WR_WORDS 16'h007B
// Byte positions and frame lengths.
`define MBS_POS_RDATA 9'h009
`define MBS_POS_WDATA 9'h00D
`define MBS_MIN_FRAME 9'h008
`define MBS_FIXED_LEN 9'h00C
`define MBS_EXC_LEN 9'h009
`define MBS_HDR_LEN 9'h006
`endif

// ### design/mbs_pkg.sv
package mbs_pkg;
  // Interpreter phases: collecting a request or sending its answer.
  typedef enum logic [0:0] {
    MBS_RX = 1'b0,
    MBS_TX = 1'b1
  } mbs_state_t;
endpackage

// ### design/mbs_bit_pack.sv
`timescale 1ns/1ps
module mbs_bit_pack (
  // Bit area and the window to pack.
  input wire logic [1023:0] area,
  input wire logic [11:0] startBit,
  input wire logic [15:0] bitsLeft,
  // Packed byte, lowest address in bit zero.
  output logic [7:0] packedBits
);
  import mbs_pkg::*;

  // Each lane picks one area bit; lanes past the requested count read zero.
  for (genvar i = 0; i < 8; i++) begin : gLane
    logic [11:0] pos;
    assign pos = startBit + 12'(i);
    assign packedBits[i] = (bitsLeft > 16'(i)) && !pos[11] && !pos[10] ? area[pos[9:0]] : 1'b0;
  end
endmodule

// ### design/mbs_server.sv
`timescale 1ns/1ps
`include "mbs_defs.svh"
module mbs_server (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Request byte stream.
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxLast,
  output logic rxReady,
  // Response byte stream.
  output logic [7:0] txData,
  output logic txValid,
  output logic txLast,
  input wire logic txReady,
  // Process image.
  input wire logic [1023:0] inputBitArea,
  input wire logic [1023:0] inputWordArea,
  output logic [1023:0] outputBitArea
);
  import mbs_pkg::*;

  mbs_state_t state;
  logic [8:0] rxCnt;
  logic [8:0] txIdx;
  logic justEntered;
  logic [15:0] tid;
  logic [15:0] pid;
  logic [15:0] addr;
  logic [15:0] qty;
  logic [7:0] unitId;
  logic [7:0] fc;
  logic [7:0] byteCnt;
  logic [7:0] hiByte;
  logic [1023:0] inBitS1;
  logic [1023:0] inBitSync;
  logic [1023:0] inWordS1;
  logic [1023:0] inWordSync;
  logic [15:0] memWord [32768];
  logic funcBad;
  logic valBad;
  logic addrBad;
  logic fieldErr;
  logic lenErr;
  logic reqErr;
  logic isRead;
  logic [7:0] excCode;
  logic [16:0] endAddr;
  logic [8:0] needLen;
  logic [8:0] respLen;
  logic [8:0] lenField;
  logic [7:0] respBc;
  logic [8:0] selIdx;
  logic [8:0] dataIdx;
  logic [11:0] startBit;
  logic [15:0] bitsLeft;
  logic [15:0] rdWordAddr;
  logic [15:0] rdWord;
  logic [7:0] packedByte;
  logic [7:0] next_txData;
  logic rxFire;
  logic bitsWrFire;
  logic [8:0] bitByteIdx;
  logic [8:0] wordIdx;
  logic wordWrEn;
  logic [15:0] wordWrAddr;
  logic [15:0] wordWrData;

  // Stream handshakes are plain decodes of the phase.
  assign rxReady = (state == MBS_RX);
  assign txValid = (state == MBS_TX);
  assign txLast = (state == MBS_TX) && (txIdx == respLen - 9'h001);
  assign rxFire = rxReady && rxValid;

  // Input pins are asynchronous to clk, so both areas pass two flops.
  always_ff @(posedge clk) begin
    inBitS1 <= inputBitArea;
    inBitSync <= inBitS1;
    inWordS1 <= inputWordArea;
    inWordSync <= inWordS1;
  end

  // Request fields are caught by byte position; later bytes pass through hiByte.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tid <= 16'h0000;
      pid <= 16'h0000;
      unitId <= 8'h00;
      fc <= 8'h00;
      addr <= 16'h0000;
      qty <= 16'h0000;
      byteCnt <= 8'h00;
      hiByte <= 8'h00;
    end else if (rxFire) begin
      case (rxCnt)
        9'h000: tid[15:8] <= rxData;
        9'h001: tid[7:0] <= rxData;
        9'h002: pid[15:8] <= rxData;
        9'h003: pid[7:0] <= rxData;
        9'h006: unitId <= rxData;
        9'h007: fc <= rxData;
        9'h008: addr[15:8] <= rxData;
        9'h009: addr[7:0] <= rxData;
        9'h00A: qty[15:8] <= rxData;
        9'h00B: qty[7:0] <= rxData;
        9'h00C: byteCnt <= rxData;
        default: hiByte <= rxData;
      endcase
    end
  end

  // Request checks; the length field is not trusted, the frame end is.
  always_comb begin
    endAddr = {1'b0, addr} + {1'b0, qty} - 17'h0_0001;
    funcBad = 1'b0;
    valBad = 1'b0;
    addrBad = 1'b0;
    case (fc)
      `MBS_FC_RD_BITS: begin
        valBad = (qty == 16'h0000) || (qty > `MBS_MAX_RD_BITS);
        addrBad = !((addr >= `MBS_IBIT_LO) && (endAddr <= {1'b0, `MBS_IBIT_HI}) ||
          (addr >= `MBS_QBIT_LO) && (endAddr <= {1'b0, `MBS_QBIT_HI}));
      end
      `MBS_FC_RD_WORDS: begin
        valBad = (qty == 16'h0000) || (qty > `MBS_MAX_RD_WORDS);
        addrBad = !((endAddr <= {1'b0, `MBS_MWORD_HI}) ||
          (addr >= `MBS_IWORD_LO) && (endAddr <= {1'b0, `MBS_IWORD_HI}) ||
          (addr >= `MBS_QWORD_LO) && (endAddr <= {1'b0, `MBS_QWORD_HI}));
      end
      `MBS_FC_WR_BIT: begin
        valBad = (qty != `MBS_BIT_OFF) && (qty != `MBS_BIT_ON);
        addrBad = (addr < `MBS_QBIT_LO) || (addr > `MBS_QBIT_HI);
      end
      `MBS_FC_WR_WORD: begin
        addrBad = !((addr <= `MBS_MWORD_HI) ||
          (addr >= `MBS_QWORD_LO) && (addr <= `MBS_QWORD_HI));
      end
      `MBS_FC_WR_BITS: begin
        valBad = (qty == 16'h0000) || (qty > `MBS_MAX_WR_BITS) ||
          (byteCnt != 8'(qty[10:3] + {7'h00, qty[2:0] != 3'h0}));
        addrBad = (addr < `MBS_QBIT_LO) || (endAddr > {1'b0, `MBS_QBIT_HI});
      end
      `MBS_FC_WR_WORDS: begin
        valBad = (qty == 16'h0000) || (qty > `MBS_MAX_WR_WORDS) ||
          (byteCnt != {qty[6:0], 1'b0});
        addrBad = !((endAddr <= {1'b0, `MBS_MWORD_HI}) ||
          (addr >= `MBS_QWORD_LO) && (endAddr <= {1'b0, `MBS_QWORD_HI}));
      end
      default: funcBad = 1'b1;
    endcase
    isRead = (fc == `MBS_FC_RD_BITS) || (fc == `MBS_FC_RD_WORDS);
    needLen = (fc == `MBS_FC_WR_BITS) || (fc == `MBS_FC_WR_WORDS) ?
      `MBS_POS_WDATA + {1'b0, byteCnt} : `MBS_FIXED_LEN;
    lenErr = rxCnt < needLen;
    fieldErr = funcBad || valBad || addrBad;
    // Function first, then value and length, then address.
    excCode = funcBad ? `MBS_EXC_FUNC : (valBad || lenErr) ? `MBS_EXC_VALUE :
      addrBad ? `MBS_EXC_ADDR : 8'h00;
    reqErr = excCode != 8'h00;
  end

  // Read answer length comes from the requested quantity; write and exception answers have fixed lengths.
  always_comb begin
    respBc = (fc == `MBS_FC_RD_BITS) ? 8'(qty[10:3] + {7'h00, qty[2:0] != 3'h0}) :
      {qty[6:0], 1'b0};
    respLen = reqErr ? `MBS_EXC_LEN : isRead ? `MBS_POS_RDATA + {1'b0, respBc} :
      `MBS_FIXED_LEN;
    lenField = respLen - `MBS_HDR_LEN;
  end

  // Read addressing for the byte that is loaded next.
  always_comb begin
    selIdx = (state == MBS_RX) ? 9'h000 : txIdx + 9'h001;
    dataIdx = selIdx - `MBS_POS_RDATA;
    startBit = {2'b00, addr[9:0]} + {dataIdx, 3'b000};
    bitsLeft = qty - {4'h0, dataIdx, 3'b000};
    rdWordAddr = addr + {8'h00, dataIdx[8:1]};
    if (!rdWordAddr[15]) begin
      rdWord = memWord[rdWordAddr[14:0]];
    end else if (rdWordAddr[13]) begin
      rdWord = outputBitArea[{rdWordAddr[5:0], 4'h0} +: 16];
    end else begin
      rdWord = inWordSync[{rdWordAddr[5:0], 4'h0} +: 16];
    end
  end

  // Bit reads come from the synchronised inputs or the output image.
  mbs_bit_pack uPack (
    .area(addr[15] ? outputBitArea : inBitSync),
    .startBit(startBit),
    .bitsLeft(bitsLeft),
    .packedBits(packedByte)
  );

  // Response byte at position selIdx.
  always_comb begin
    case (selIdx)
      9'h000: next_txData = tid[15:8];
      9'h001: next_txData = tid[7:0];
      9'h002: next_txData = pid[15:8];
      9'h003: next_txData = pid[7:0];
      9'h004: next_txData = {7'h00, lenField[8]};
      9'h005: next_txData = lenField[7:0];
      9'h006: next_txData = unitId;
      9'h007: next_txData = reqErr ? (fc | `MBS_EXC_FLAG) : fc;
      9'h008: next_txData = reqErr ? excCode : isRead ? respBc : addr[15:8];
      default: begin
        if (isRead) begin
          next_txData = (fc == `MBS_FC_RD_BITS) ? packedByte :
            dataIdx[0] ? rdWord[7:0] : rdWord[15:8];
        end else begin
          next_txData = (selIdx == 9'h009) ? addr[7:0] :
            (selIdx == 9'h00A) ? qty[15:8] : qty[7:0];
        end
      end
    endcase
  end

  // Phase control; a frame of fewer than eight bytes is dropped unanswered.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= MBS_RX;
      rxCnt <= 9'h000;
      txIdx <= 9'h000;
      txData <= 8'h00;
      justEntered <= 1'b0;
    end else begin
      justEntered <= 1'b0;
      case (state)
        MBS_RX: begin
          if (rxFire) begin
            rxCnt <= (rxCnt == 9'h1FF) ? rxCnt : rxCnt + 9'h001;
            if (rxLast && (rxCnt + 9'h001 < `MBS_MIN_FRAME)) begin
              rxCnt <= 9'h000;
            end else if (rxLast) begin
              state <= MBS_TX;
              txIdx <= 9'h000;
              txData <= next_txData;
              justEntered <= 1'b1;
            end
          end
        end
        MBS_TX: begin
          if (txReady && txLast) begin
            state <= MBS_RX;
            rxCnt <= 9'h000;
          end else if (txReady) begin
            txIdx <= txIdx + 9'h001;
            txData <= next_txData;
          end
        end
        default: state <= MBS_RX;
      endcase
    end
  end

  // Streaming writes start once the byte count is in, so checks are settled.
  always_comb begin
    bitByteIdx = rxCnt - `MBS_POS_WDATA;
    wordIdx = (rxCnt - `MBS_POS_WDATA - 9'h001) >> 1;
    bitsWrFire = rxFire && (fc == `MBS_FC_WR_BITS) && !fieldErr &&
      (rxCnt >= `MBS_POS_WDATA);
    wordWrEn = 1'b0;
    wordWrAddr = addr;
    wordWrData = qty;
    if (justEntered && !reqErr && (fc == `MBS_FC_WR_WORD)) begin
      wordWrEn = 1'b1;
    end else if (rxFire && (fc == `MBS_FC_WR_WORDS) && !fieldErr &&
      (rxCnt > `MBS_POS_WDATA) && !rxCnt[0] && ({7'h00, wordIdx} < qty)) begin
      wordWrEn = 1'b1;
      wordWrAddr = addr + {7'h00, wordIdx};
      wordWrData = {hiByte, rxData};
    end
  end

  // Memory words hold data only and need no reset.
  always_ff @(posedge clk) begin
    if (wordWrEn && !wordWrAddr[15]) begin
      memWord[wordWrAddr[14:0]] <= wordWrData;
    end
  end

  // Each output bit takes single, packed or word writes; they never coincide.
  for (genvar g = 0; g < 1024; g++) begin : gOut
    localparam logic [9:0] GI = 10'(g);
    logic [10:0] rel;
    assign rel = {1'b0, GI} - {1'b0, addr[9:0]};
    always_ff @(posedge clk) begin
      if (!nrst) begin
        outputBitArea[g] <= 1'b0;
      end else if (justEntered && !reqErr && (fc == `MBS_FC_WR_BIT) && (rel == 11'h000)) begin
        outputBitArea[g] <= (qty == `MBS_BIT_ON);
      end else if (bitsWrFire && !rel[10] && ({5'h00, rel} < qty) &&
        ({2'b00, rel[9:3]} == bitByteIdx)) begin
        outputBitArea[g] <= rxData[rel[2:0]];
      end else if (wordWrEn && (wordWrAddr[15:12] == 4'hA) && (wordWrAddr[5:0] == GI[9:4])) begin
        outputBitArea[g] <= wordWrData[GI[3:0]];
      end
    end
  end

  // Checks on the answer stream and the output image.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  hdr_echo_a: assert property ((state == MBS_TX) && (txIdx == 9'h000) |->
    txData == tid[15:8])
    else $error("first answer byte is not the transaction id high byte");
  exc_fc_a: assert property ((state == MBS_TX) && reqErr && (txIdx == 9'h007) |->
    txData == (fc | 8'h80))
    else $error("exception function byte wrong");
  exc_len_a: assert property ((state == MBS_TX) && reqErr && (txIdx == 9'h008) |-> txLast)
    else $error("exception answer length wrong");
  read_bc_a: assert property ((state == MBS_TX) && !reqErr && (fc == 8'h02) &&
    (txIdx == 9'h008) |-> txData == 8'((qty + 16'h0007) >> 3))
    else $error("bit read byte count wrong");
  pad_zero_a: assert property ((state == MBS_TX) && !reqErr && (fc == 8'h02) && txLast &&
    (qty[2:0] != 3'h0) |-> (txData >> qty[2:0]) == 8'h00)
    else $error("padding bits of last byte not zero");
  word_len_a: assert property ((state == MBS_TX) && !reqErr && (fc == 8'h03) &&
    (txIdx == 9'h008) |-> txData == {qty[6:0], 1'b0})
    else $error("word read byte count wrong");
  bit_set_a: assert property ($rose(state == MBS_TX) && (fc == 8'h05) ##1 !reqErr |->
    outputBitArea[addr[9:0]] == (qty == 16'hFF00))
    else $error("single bit write not applied");
  input_ro_a: assert property ((state == MBS_TX) && ((fc == 8'h05) || (fc == 8'h0F)) &&
    (addr[15:12] == 4'h6) |-> reqErr && $stable(outputBitArea))
    else $error("write to input area not refused");
  wr_echo_a: assert property ((state == MBS_TX) && !reqErr &&
    ((fc == 8'h05) || (fc == 8'h0F)) && (txIdx == 9'h00A) |-> txData == qty[15:8])
    else $error("write echo wrong");

  exc_done_c: cover property ((state == MBS_TX) && reqErr && txLast && txReady);
  rd_bits_c: cover property ((state == MBS_TX) && !reqErr && (fc == 8'h02) && txLast && txReady);
  wr_bits_c: cover property ((state == MBS_TX) && !reqErr && (fc == 8'h0F) && txLast && txReady);
endmodule

// ### bench/mbs_client_model.sv
`timescale 1ns/1ps
module mbs_client_model (
  // Clock.
  input wire logic clk,
  // Request stream toward the server.
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxLast,
  input wire logic rxReady,
  // Response stream from the server.
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txLast,
  output logic txReady
);
  int seed = 47692;
  // Idle lines at time zero.
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    rxLast = 1'b0;
    txReady = 1'b0;
  end
  // One whole frame out, one whole answer back.
  task automatic transact(input logic [7:0] req[64], input int len,
      output logic [7:0] resp[64], output int rlen);
    logic ok;
    rlen = 0;
    for (int i = 0; i < len; i++) begin
      rxData <= req[i];
      rxValid <= 1'b1;
      rxLast <= (i == len - 1);
      do begin
        @(negedge clk);
        ok = rxReady;
        @(posedge clk);
      end while (!ok);
    end
    // A released line shows the inverse of its last byte, so no stale copy can pass.
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    rxData <= ~req[len - 1];
    // Stall about one cycle in four, as a busy client would.
    ok = 1'b0;
    while (!ok) begin
      txReady <= ($random(seed) & 3) != 0;
      @(negedge clk);
      if (txValid && txReady) begin
        resp[rlen] = txData;
        rlen++;
        ok = txLast;
      end
      @(posedge clk);
    end
    txReady <= 1'b0;
  endtask
endmodule

// ### bench/mbs_server_bench.sv
`timescale 1ns/1ps
module mbs_server_bench;
  logic clk, nrst, rxValid, rxLast, rxReady, txValid, txLast, txReady;
  logic [7:0] rxData, txData;
  logic [1023:0] inputBitArea, inputWordArea, outputBitArea, outModel;
  logic [7:0] req[64], resp[64];
  logic [15:0] tid, w0, a, q;
  int respLen, fails, compares, s, n, r;
  int seed = 47692;
  localparam logic [55:0] EXC_TAB [6] = '{
    {8'h05, 16'h6000, 16'hFF00, 16'h0002}, {8'h07, 16'hA000, 16'h0000, 16'h0001},
    {8'h05, 16'hA000, 16'h1234, 16'h0003}, {8'h02, 16'h5000, 16'h0008, 16'h0002},
    {8'h06, 16'h8000, 16'h0001, 16'h0002}, {8'h02, 16'hA000, 16'h0000, 16'h0003}};
  mbs_server mbs_server_inst (.clk(clk), .nrst(nrst), .rxData(rxData), .rxValid(rxValid),
    .rxLast(rxLast), .rxReady(rxReady), .txData(txData), .txValid(txValid),
    .txLast(txLast), .txReady(txReady), .inputBitArea(inputBitArea),
    .inputWordArea(inputWordArea), .outputBitArea(outputBitArea));
  mbs_client_model mbs_client_model_inst (.clk(clk), .rxData(rxData), .rxValid(rxValid),
    .rxLast(rxLast), .rxReady(rxReady), .txData(txData), .txValid(txValid),
    .txLast(txLast), .txReady(txReady));
  // Clock of 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Expected status byte: lowest address in bit zero, zero past the count.
  function automatic logic [7:0] packExp(logic [1023:0] v, int st, int cnt);
    for (int i = 0; i < 8; i++) packExp[i] = (i < cnt) ? v[st + i] : 1'b0;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic setup(input logic [7:0] fc, input logic [15:0] ad, input logic [15:0] qv);
    tid = $random(seed);
    {req[0], req[1], req[2], req[3], req[6], req[7]} = {tid, 16'h0000, 8'h01, fc};
    {req[8], req[9], req[10], req[11]} = {ad, qv};
  endtask
  // Send, then judge the header and the output image common to every answer.
  task automatic run(input int len, input logic [7:0] fc, input int expLen);
    {req[4], req[5]} = 16'(len - 6);
    mbs_client_model_inst.transact(req, len, resp, respLen);
    check(16'(respLen), 16'(expLen));
    check({resp[0], resp[1]}, tid);
    check({resp[2], resp[3]}, 16'h0000);
    check({resp[4], resp[5]}, 16'(respLen - 6));
    check({resp[6], resp[7]}, {8'h01, fc});
    compares++;
    if (outputBitArea !== outModel) begin
      fails++;
      $display("FAIL at %0t: output image differs", $time);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // A hang counts as a mismatch; the whole run needs under two thousand cycles.
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
  initial begin
    nrst <= 1'b0;
    outModel = '0;
    for (int k = 0; k < 32; k++) begin
      inputBitArea[32 * k +: 32] <= $random(seed);
      inputWordArea[32 * k +: 32] <= $random(seed);
    end
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // Set and clear the first output bit, then random single writes.
    for (int k = 0; k < 26; k++) begin
      r = $random(seed);
      a = (k < 2) ? 16'h0000 : 16'(r) & 16'h03FF;
      q = (k == 0 || (k > 1 && r[20])) ? 16'hFF00 : 16'h0000;
      outModel[a] = (q == 16'hFF00);
      setup(8'h05, 16'hA000 + a, q);
      run(12, 8'h05, 12);
      check({resp[8], resp[9]}, 16'hA000 + a);
      check({resp[10], resp[11]}, q);
    end
    // Thirteen bits written from output byte two, bit zero.
    setup(8'h0F, 16'hA010, 16'h000D);
    {req[12], req[13], req[14]} = {8'h02, 8'h81, 8'h11};
    outModel[16 +: 13] = 13'h1181;
    run(15, 8'h0F, 12);
    check({resp[8], resp[9]}, 16'hA010);
    check({resp[10], resp[11]}, 16'h000D);
    // Reads of both bit areas; the first reads back the window just written.
    for (int k = 0; k < 16; k++) begin
      s = (k == 0) ? 16 : ($random(seed) & 16'h03FF) % 990;
      n = (k == 0) ? 13 : 1 + ($random(seed) & 31);
      setup(8'h02, ((k & 1) ? 16'h6000 : 16'hA000) + 16'(s), 16'(n));
      run(12, 8'h02, 9 + (n + 7) / 8);
      check(resp[8], 16'((n + 7) / 8));
      for (int b = 0; b < (n + 7) / 8; b++) begin
        check(resp[9 + b], packExp((k & 1) ? inputBitArea : outModel, s + 8 * b, n - 8 * b));
      end
    end
    // Memory words written and read back, then one input and one output word.
    w0 = $random(seed);
    setup(8'h10, 16'h0020, 16'h0002);
    {req[12], req[13], req[14], req[15], req[16]} = {8'h04, w0, ~w0};
    run(17, 8'h10, 12);
    check({resp[8], resp[9]}, 16'h0020);
    check({resp[10], resp[11]}, 16'h0002);
    setup(8'h06, 16'h0022, 16'h5A5A);
    run(12, 8'h06, 12);
    check({resp[8], resp[9]}, 16'h0022);
    check({resp[10], resp[11]}, 16'h5A5A);
    setup(8'h03, 16'h0020, 16'h0003);
    run(12, 8'h03, 15);
    check(resp[8], 16'h0006);
    check({resp[9], resp[10]}, w0);
    check({resp[11], resp[12]}, ~w0);
    check({resp[13], resp[14]}, 16'h5A5A);
    setup(8'h03, 16'h8005, 16'h0001);
    run(12, 8'h03, 11);
    check({resp[9], resp[10]}, inputWordArea[80 +: 16]);
    setup(8'h03, 16'hA001, 16'h0001);
    run(12, 8'h03, 11);
    check({resp[9], resp[10]}, outModel[16 +: 16]);
    // Refused requests leave the image untouched and name the cause.
    for (int k = 0; k < 6; k++) begin
      setup(EXC_TAB[k][55:48], EXC_TAB[k][47:32], EXC_TAB[k][31:16]);
      run(12, EXC_TAB[k][55:48] | 8'h80, 9);
      check(resp[8], EXC_TAB[k][15:0]);
    end
    // A single bit write cut after ten bytes is refused as a bad value and writes nothing.
    setup(8'h05, 16'hA3FF, 16'hFF00);
    run(10, 8'h85, 9);
    check(resp[8], 16'h0003);
    tally_and_finish();
  end
endmodule
